// File: verilog/sesp_port.sv
// sesp_port: pin-level serial slave port of a small byte-wide memory
// assumes all link pins arrive asynchronously and are sampled on clk;
// user logic on clk decodes instructions and feeds read bytes
`timescale 1ns/1ps
`default_nettype none

module sesp_port (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     spi_sclk,
  input  wire logic                     spi_cs_n,
  input  wire logic                     spi_mosi,
  input  wire logic                     spi_hold_n,
  input  wire logic                     spi_wp_n,
  input  wire logic                     por_ok,
  output logic                          spi_miso_o,
  output logic                          spi_miso_oe,
  output logic [sesp_pkg::BYTE_W-1:0]   rx_byte,
  output logic                          rx_valid,
  output logic                          rx_first,
  input  wire logic [sesp_pkg::BYTE_W-1:0] tx_byte,
  input  wire logic                     tx_load,
  output logic                          tx_need,
  output logic                          frame_end,
  output logic                          selected,
  output logic                          paused,
  output logic                          standby,
  output logic                          write_allowed,
  input  wire logic                     wel_set,
  input  wire logic                     wel_clr,
  input  wire logic                     wip_set,
  input  wire logic                     wip_clr,
  input  wire logic                     nv_load,
  input  wire logic [sesp_pkg::NV_W-1:0] nv_data,
  output logic [sesp_pkg::BYTE_W-1:0]   status_byte
);
  import sesp_pkg::*;

  function automatic logic edge_of(input logic now_v, input logic was_v,
                                   input logic rising);
    edge_of = rising ? (now_v & ~was_v) : (~now_v & was_v);
  endfunction

  logic [SYNC_W-1:0] sy;
  logic              sclk_s;
  logic              cs_s;
  logic              mosi_s;
  logic              hold_s;
  logic              wp_s;
  logic              por_s;

  sesp_sync #(
    .W   (SYNC_W),
    .RST (SYNC_RST)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     ({por_ok, spi_wp_n, spi_hold_n, spi_mosi, spi_cs_n, spi_sclk}),
    .dout    (sy)
  );

  assign sclk_s = sy[SY_SCLK];
  assign cs_s   = sy[SY_CS];
  assign mosi_s = sy[SY_MOSI];
  assign hold_s = sy[SY_HOLD];
  assign wp_s   = sy[SY_WP];
  assign por_s  = sy[SY_POR];

  logic        sclk_prev_reg;
  logic        cs_prev_reg;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
      cs_prev_reg   <= cs_s;
    end
  end

  assign sclk_rise = edge_of(sclk_s, sclk_prev_reg, 1'b1);
  assign sclk_fall = edge_of(sclk_s, sclk_prev_reg, 1'b0);
  // cs_prev_reg resets low, so a pin held low at power-up never counts
  assign cs_fall   = edge_of(cs_s, cs_prev_reg, 1'b0);

  sesp_state_t st_reg;
  sesp_state_t st_next;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      SESP_IDLE: begin
        if (cs_fall && por_s) begin
          st_next = SESP_ACTIVE;
        end
      end
      SESP_ACTIVE: begin
        if (cs_s) begin
          st_next = SESP_IDLE;
        end else if (!hold_s && !sclk_s) begin
          st_next = SESP_PAUSE;
        end
      end
      SESP_PAUSE: begin
        if (cs_s) begin
          st_next = SESP_IDLE;
        end else if (hold_s && !sclk_s) begin
          st_next = SESP_ACTIVE;
        end
      end
      default: begin
        st_next = SESP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= SESP_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  logic active;
  assign active = (st_reg == SESP_ACTIVE);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frame_end <= 1'b0;
    end else begin
      frame_end <= (st_reg != SESP_IDLE) && (st_next == SESP_IDLE);
    end
  end

  logic [BYTE_W-1:0] sh_in_reg;
  logic [2:0]        bit_cnt_reg;
  logic              first_reg;

  // receive shifter; edges seen in pause are dropped, not queued
  always_ff @(posedge clk) begin
    if (sys_rst || st_reg == SESP_IDLE) begin
      sh_in_reg   <= '0;
      bit_cnt_reg <= BIT_FIRST;
      first_reg   <= 1'b1;
      rx_valid    <= 1'b0;
      rx_first    <= 1'b0;
      rx_byte     <= '0;
    end else begin
      rx_valid <= 1'b0;
      if (active && sclk_rise) begin
        sh_in_reg   <= {sh_in_reg[BYTE_W-2:0], mosi_s};
        bit_cnt_reg <= bit_cnt_reg + BIT_STEP;
        if (bit_cnt_reg == BIT_LAST) begin
          rx_byte   <= {sh_in_reg[BYTE_W-2:0], mosi_s};
          rx_valid  <= 1'b1;
          rx_first  <= first_reg;
          first_reg <= 1'b0;
        end
      end
    end
  end

  logic [BYTE_W-1:0] tx_buf_reg;
  logic              tx_pend_reg;
  logic [BYTE_W-1:0] tx_sh_reg;
  logic [2:0]        tx_cnt_reg;
  logic              drive_reg;
  logic              tx_take;

  assign tx_take = active && sclk_fall && tx_pend_reg &&
                   (tx_cnt_reg == BIT_FIRST);

  // holding buffer; a new load wins over the take in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst || st_reg == SESP_IDLE) begin
      tx_buf_reg  <= '0;
      tx_pend_reg <= 1'b0;
    end else if (tx_load) begin
      tx_buf_reg  <= tx_byte;
      tx_pend_reg <= 1'b1;
    end else if (tx_take) begin
      tx_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || st_reg == SESP_IDLE) begin
      tx_sh_reg  <= '0;
      tx_cnt_reg <= BIT_FIRST;
      drive_reg  <= 1'b0;
      spi_miso_o <= 1'b0;
      tx_need    <= 1'b0;
    end else begin
      tx_need <= 1'b0;
      if (tx_take) begin
        spi_miso_o <= tx_buf_reg[BYTE_W-1];
        tx_sh_reg  <= {tx_buf_reg[BYTE_W-2:0], 1'b0};
        tx_cnt_reg <= BIT_STEP;
        drive_reg  <= 1'b1;
        tx_need    <= 1'b1;
      // underrun shifts zeros rather than stalling the master
      end else if (active && sclk_fall && drive_reg) begin
        spi_miso_o <= tx_sh_reg[BYTE_W-1];
        tx_sh_reg  <= {tx_sh_reg[BYTE_W-2:0], 1'b0};
        tx_cnt_reg <= tx_cnt_reg + BIT_STEP;
      end
    end
  end

  assign spi_miso_oe = drive_reg && active;

  logic wel_reg;
  logic wip_reg;
  logic [NV_W-1:0] nv_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wel_reg <= 1'b0;
    end else if (wel_set) begin
      wel_reg <= 1'b1;
    end else if (wel_clr) begin
      wel_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wip_reg <= 1'b0;
    end else if (wip_set) begin
      wip_reg <= 1'b1;
    end else if (wip_clr) begin
      wip_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (nv_load) begin
      nv_reg <= nv_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      write_allowed <= 1'b0;
    end else begin
      write_allowed <= wp_s && por_s;
    end
  end

  always_comb begin
    status_byte          = '0;
    status_byte[ST_WIP]  = wip_reg;
    status_byte[ST_WEL]  = wel_reg;
    status_byte[ST_BPLO] = nv_reg[NV_BPLO];
    status_byte[ST_BPHI] = nv_reg[NV_BPHI];
    status_byte[ST_SWD]  = nv_reg[NV_SWD];
  end

  assign selected = (st_reg != SESP_IDLE);
  assign paused   = (st_reg == SESP_PAUSE);
  // standby only when idle and not writing
  assign standby  = (st_reg == SESP_IDLE) && !wip_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  deselect_float_a: assert property (
    (st_reg == SESP_IDLE) |-> !spi_miso_oe)
    else $error("output driven while deselected");

  pause_float_a: assert property (
    paused |-> !spi_miso_oe)
    else $error("output driven while paused");

  pause_ignore_a: assert property (
    (paused && sclk_rise) |=> (bit_cnt_reg == $past(bit_cnt_reg)))
    else $error("clock edge counted during pause");

  select_edge_a: assert property (
    $rose(selected) |-> ($past(cs_fall) && $past(por_s)))
    else $error("selected without falling chip select");

  rx_msb_first_a: assert property (
    rx_valid |-> (rx_byte[0] == $past(mosi_s) &&
                  $past(bit_cnt_reg) == BIT_LAST))
    else $error("received byte misordered");

  tx_msb_first_a: assert property (
    (tx_take && hold_s && !cs_s) |=>
      (spi_miso_o == $past(tx_buf_reg[BYTE_W-1]) && spi_miso_oe))
    else $error("read data not started with msb");

  pause_entry_a: assert property (
    (active && !cs_s && !hold_s && !sclk_s) |=> paused)
    else $error("pause not entered");

  pause_abort_a: assert property (
    (paused && cs_s) |=> (st_reg == SESP_IDLE) ##1 (bit_cnt_reg == BIT_FIRST))
    else $error("deselect in pause did not reset");

  status_reset_a: assert property (
    $past(sys_rst) |-> (!wel_reg && !wip_reg && standby))
    else $error("status not cleared by reset");

  wip_set_wins_a: assert property (
    (wip_set && wip_clr) |=> wip_reg)
    else $error("busy set lost to clear");

  standby_exit_a: assert property (
    (st_reg == SESP_IDLE && cs_fall && por_s) |=> !standby)
    else $error("still standby after select");

  byte_rx_c: cover property (rx_valid && rx_first);
  pause_c: cover property (active ##1 paused ##[1:100] active);
  read_out_c: cover property ($rose(spi_miso_oe));
  abort_c: cover property (paused ##1 (st_reg == SESP_IDLE));

endmodule

`default_nettype wire

// File: verilog/sesp_pkg.sv
// sesp_pkg: constants and types for the serial memory slave port
// assumes one 125 MHz system clock and a synchronous active-high reset
`default_nettype none

package sesp_pkg;

  // synchroniser lanes
  localparam int SYNC_W  = 6;
  localparam int SY_SCLK = 0;
  localparam int SY_CS   = 1;
  localparam int SY_MOSI = 2;
  localparam int SY_HOLD = 3;
  localparam int SY_WP   = 4;
  localparam int SY_POR  = 5;

  // chip select resets low so the reset value never looks like a high
  localparam logic [SYNC_W-1:0] SYNC_RST = 6'h18;

  localparam int          BYTE_W    = 8;
  localparam logic [2:0]  BIT_FIRST = 3'h0;
  localparam logic [2:0]  BIT_LAST  = 3'h7;
  localparam logic [2:0]  BIT_STEP  = 3'h1;

  // status byte layout
  localparam int ST_WIP  = 0;
  localparam int ST_WEL  = 1;
  localparam int ST_BPLO = 2;
  localparam int ST_BPHI = 3;
  localparam int ST_SWD  = 7;
  localparam int NV_W    = 3;
  localparam int NV_BPLO = 0;
  localparam int NV_BPHI = 1;
  localparam int NV_SWD  = 2;

  // link clock period used by the bench, in ns
  localparam int LINK_PERIOD_NS = 160;

  typedef enum logic [2:0] {
    SESP_IDLE   = 3'h1,
    SESP_ACTIVE = 3'h2,
    SESP_PAUSE  = 3'h4
  } sesp_state_t;

endpackage

`default_nettype wire

// File: verilog/sesp_sync.sv
// sesp_sync: two-flop synchroniser for a vector of pin inputs
// assumes each lane is an independent level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module sesp_sync #(
  parameter int               W   = 1,
  parameter logic [W-1:0]     RST = '0
) (
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic [W-1:0]   din,
  output logic      [W-1:0]   dout
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_reg <= RST;
      dout     <= RST;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// File: sim/sesp_spi_master.sv
// sesp_spi_master: behavioural bus master for the serial slave port
// assumes clk paces every pin change; one device on the bus
`timescale 1ns/1ps
`default_nettype none

module sesp_spi_master (
  input  wire logic clk,
  input  wire logic spi_miso_o,
  input  wire logic spi_miso_oe,
  output var logic  spi_sclk,
  output var logic  spi_cs_n,
  output var logic  spi_mosi,
  output var logic  spi_hold_n
);
  logic       cpol;
  logic       miso_q = 1'b0;
  logic [7:0] rxq;
  // released line shows a moving pattern, never a stale bit
  wire        miso_w = spi_miso_oe ? spi_miso_o : ~miso_q;

  always @(posedge clk) miso_q <= miso_w;

  // cs low from power-up: the port must not take it as a select
  initial begin
    spi_cs_n = 1'b0;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
    spi_hold_n = 1'b1;
    cpol = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic sel(input logic mode);
    @(posedge clk);
    cpol = mode;
    spi_sclk <= mode;
    w(4);
    spi_cs_n <= 1'b0;
    w(5);
  endtask

  task automatic desel();
    @(posedge clk);
    spi_cs_n <= 1'b1;
    w(6);
    spi_sclk <= cpol;
    w(4);
  endtask

  task automatic xfer(input logic [7:0] d, input int n);
    @(posedge clk);
    for (int i = 7; i > 7 - n; i--) begin
      spi_sclk <= 1'b0;
      spi_mosi <= d[i];
      w(10);
      spi_sclk <= 1'b1;
      rxq <= {rxq[6:0], miso_w};
      w(10);
    end
  endtask

  // pause only while selected
  // clock and data wiggle while paused; the port must ignore them
  task automatic hold_on();
    @(posedge clk);
    spi_sclk <= 1'b0;
    w(5);
    spi_hold_n <= 1'b0;
    w(6);
    repeat (2) begin
      spi_sclk <= 1'b1;
      spi_mosi <= ~spi_mosi;
      w(10);
      spi_sclk <= 1'b0;
      w(10);
    end
  endtask

  task automatic hold_off();
    @(posedge clk);
    spi_hold_n <= 1'b1;
    w(6);
  endtask
endmodule

`default_nettype wire

// File: sim/tb_sesp_port.sv
// tb_sesp_port: self-checking bench for the serial slave port
// assumes sesp_pkg and sesp_port compiled first; master model drives pins
`timescale 1ns/1ps
`default_nettype none

module tb_sesp_port;
  import sesp_pkg::*;
  localparam int TMO_CYC = 20000;
  // read byte is derived from the received byte, so it is never fixed
  localparam logic [BYTE_W-1:0] TX_MASK = 8'h39;
  logic              clk = 1'b0;
  logic              sys_rst;
  logic              spi_wp_n;
  logic              por_ok;
  logic              tx_load;
  logic              wel_set;
  logic              wel_clr;
  logic              wip_set;
  logic              wip_clr;
  logic              nv_load;
  logic              arm;
  logic [NV_W-1:0]   nv_data;
  logic [BYTE_W-1:0] tx_byte;
  logic [BYTE_W-1:0] rx_byte;
  logic [BYTE_W-1:0] status_byte;
  logic [BYTE_W-1:0] got_b;
  logic              got_f;
  logic              rx_valid;
  logic              rx_first;
  logic              frame_end;
  logic              tx_need;
  logic              selected;
  logic              paused;
  logic              standby;
  logic              write_allowed;
  logic              spi_miso_o;
  logic              spi_miso_oe;
  wire               spi_sclk;
  wire               spi_cs_n;
  wire               spi_mosi;
  wire               spi_hold_n;
  int                errors = 0;
  int                num_checks = 0;
  int                cyc = 0;
  int                fe = 0;
  int                nt = 0;
  int                fe0;

  sesp_port uut (
    .clk, .sys_rst, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_hold_n,
    .spi_wp_n, .por_ok, .spi_miso_o, .spi_miso_oe, .rx_byte, .rx_valid,
    .rx_first, .tx_byte, .tx_load, .tx_need, .frame_end, .selected,
    .paused, .standby, .write_allowed, .wel_set, .wel_clr, .wip_set,
    .wip_clr, .nv_load, .nv_data, .status_byte
  );

  sesp_spi_master m (
    .clk, .spi_miso_o, .spi_miso_oe, .spi_sclk, .spi_cs_n, .spi_mosi,
    .spi_hold_n
  );

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic wrap_up();
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h want %h", $time, seen, exp);
    end
  endtask

  // one-cycle pulse of wel_set, wel_clr, wip_set, wip_clr, nv_load
  task automatic ctl(input logic [4:0] v, input logic [NV_W-1:0] nv);
    @(posedge clk);
    {wel_set, wel_clr, wip_set, wip_clr, nv_load} <= v;
    nv_data <= nv;
    @(posedge clk);
    {wel_set, wel_clr, wip_set, wip_clr, nv_load} <= 5'h00;
  endtask

  // read byte offered right after each received byte, only when armed
  always @(posedge clk) begin
    tx_load <= rx_valid & arm;
    if (rx_valid) begin
      tx_byte <= rx_byte ^ TX_MASK;
      got_b <= rx_byte;
      got_f <= rx_first;
    end
    if (frame_end) fe <= fe + 1;
    if (tx_need) nt <= nt + 1;
    cyc <= cyc + 1;
    if (cyc == TMO_CYC) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    sys_rst = 1'b1;
    spi_wp_n = 1'b1;
    por_ok = 1'b1;
    wel_set = 1'b0;
    wel_clr = 1'b0;
    wip_set = 1'b0;
    wip_clr = 1'b0;
    nv_load = 1'b0;
    nv_data = 3'h0;
    arm = 1'b0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    m.w(10);
    @(negedge clk);
    check(selected, 1'b0);
    m.desel();
    ctl(5'h15, 3'h5);
    @(negedge clk);
    check(status_byte, 8'h87);
    check(standby, 1'b0);
    @(posedge clk);
    sys_rst <= 1'b1;
    m.w(2);
    sys_rst <= 1'b0;
    m.w(2);
    @(negedge clk);
    check(status_byte, 8'h84);
    check(standby, 1'b1);
    check(selected, 1'b0);
    // set and clear in one cycle: set wins
    ctl(5'h1e, 3'h0);
    @(negedge clk);
    check(status_byte, 8'h87);
    ctl(5'h0a, 3'h0);
    @(negedge clk);
    check(status_byte, 8'h84);
    @(posedge clk);
    por_ok <= 1'b0;
    m.sel(1'b0);
    @(negedge clk);
    check(selected, 1'b0);
    m.desel();
    por_ok <= 1'b1;
    spi_wp_n <= 1'b0;
    m.w(6);
    @(negedge clk);
    check(write_allowed, 1'b0);
    // read with writes blocked: everything else must still work
    arm = 1'b1;
    m.sel(1'b0);
    @(negedge clk);
    check(standby, 1'b0);
    m.xfer(8'h05, 8);
    @(negedge clk);
    check(got_b, 8'h05);
    check(got_f, 1'b1);
    check(spi_miso_oe, 1'b0);
    m.xfer(8'h96, 4);
    @(negedge clk);
    check(spi_miso_oe, 1'b1);
    m.hold_on();
    @(negedge clk);
    check(paused, 1'b1);
    check(selected, 1'b1);
    check(spi_miso_oe, 1'b0);
    m.hold_off();
    @(negedge clk);
    check(paused, 1'b0);
    m.xfer(8'h60, 4);
    @(negedge clk);
    check(m.rxq, 8'h3c);
    check(8'(nt), 8'h01);
    check(got_b, 8'h96);
    check(got_f, 1'b0);
    arm = 1'b0;
    m.desel();
    spi_wp_n <= 1'b1;
    m.w(6);
    @(negedge clk);
    check(spi_miso_oe, 1'b0);
    check(standby, 1'b1);
    check(write_allowed, 1'b1);
    m.sel(1'b1);
    m.xfer(8'h5a, 8);
    @(negedge clk);
    check(got_b, 8'h5a);
    check(got_f, 1'b1);
    m.desel();
    m.sel(1'b0);
    m.xfer(8'hf0, 4);
    m.hold_on();
    fe0 = fe;
    m.desel();
    @(negedge clk);
    check(paused, 1'b0);
    check(selected, 1'b0);
    check(8'(fe - fe0), 8'h01);
    m.hold_off();
    m.sel(1'b0);
    m.xfer(8'he7, 8);
    @(negedge clk);
    check(got_b, 8'he7);
    check(got_f, 1'b1);
    m.desel();
    wrap_up();
  end
endmodule

`default_nettype wire
